// ===== hw/acs_map.vh
// Operation
// - The status top byte reports the request queue depth, 32 requests by default (1Fh).
// - The low six bits of that byte follow the control queue field and the top two read zero.
// - Only queue depths of 32, 16, 8, 4, 2 or 1 requests can be selected.
// - The sideband addressing capability bit always reads one.
// - The above-4G support bit always reads zero.
// - The fast-write support bit always reads zero.
// - The rate field holds one bit per mode: bit 0 1x, bit 1 2x, bit 2 4x.
// - The 4x capability bit reads zero while the 4x override control bit is set.
// - After reset the rate capability field reads 111.
// - The selected rate drives both the address/data bus and the sideband bus.
// - The command word is a 32-bit register, writable only in bits 9:8, 4 and 2:0, that resets to zero.
// - With the port disabled new operations are ignored, accepted ones still complete.
// - An enabled port takes pipelined requests, and sideband ones only with sideband enabled.
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
`define ACS_OFF_STATUS    8'ha4
`define ACS_OFF_COMMAND   8'ha8
`define ACS_OFF_CONTROL   8'hac
`define ACS_CMD_RESET     32'h00000000
`define ACS_CMD_WMASK     32'h00000317
`define ACS_CTL_RESET     32'h00000000
`define ACS_CTL_WMASK     32'h00001c01
`define ACS_CTL_OVR_BIT   0
`define ACS_CTL_QDEP_LSB  10
`define ACS_CMD_RATE_LSB  0
`define ACS_CMD_FWE_BIT   4
`define ACS_CMD_EN_BIT    8
`define ACS_CMD_SBE_BIT   9
`define ACS_STAT_SBA_BIT  9
`define ACS_STAT_QDEP_LSB 24
`define ACS_RATE_ALL      3'h7
`endif

// ===== hw/acs_regs.v
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`include "acs_map.vh"
module acs_regs (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // Register port
    input  wire [7:0]  regAddr,
    input  wire [31:0] regWdata,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdata,
    // Incoming operation requests
    input  wire        pipeReq,
    input  wire        sbaReq,
    input  wire        opPending,
    // Port state
    output wire        pipeAccept,
    output wire        sbaAccept,
    output wire        opService,
    output wire [2:0]  adRate,
    output wire [2:0]  sbaRate,
    output wire [5:0]  queueDepth,
    output wire        portEnable
);
    reg  [31:0] cmdQ;
    reg  [31:0] ctlQ;
    wire [31:0] statusWord;
    wire [2:0]  rateCap;
    wire [2:0]  rqSel;

    // Select code to queue depth minus one; illegal codes fall back to 32
    function [5:0] depthOf;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    depthOf = 6'h1f;
                3'h1:    depthOf = 6'h0f;
                3'h2:    depthOf = 6'h07;
                3'h3:    depthOf = 6'h03;
                3'h4:    depthOf = 6'h01;
                3'h5:    depthOf = 6'h00;
                default: depthOf = 6'h1f;
            endcase
        end
    endfunction

    assign rqSel = ctlQ[`ACS_CTL_QDEP_LSB+2:`ACS_CTL_QDEP_LSB];
    assign queueDepth = depthOf(rqSel);
    assign rateCap = {~ctlQ[`ACS_CTL_OVR_BIT], 2'h3} & `ACS_RATE_ALL;

    assign statusWord = {2'h0, queueDepth,
                         14'h0,
                         1'h1,
                         3'h0,
                         1'h0,
                         1'h0,
                         1'h0,
                         rateCap};

    // Only the documented fields are writable
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmdQ <= `ACS_CMD_RESET;
            ctlQ <= `ACS_CTL_RESET;
        end else if (regWr) begin
            if (regAddr == `ACS_OFF_COMMAND)
                cmdQ <= regWdata & `ACS_CMD_WMASK;
            if (regAddr == `ACS_OFF_CONTROL)
                ctlQ <= regWdata & `ACS_CTL_WMASK;
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdata <= 32'h00000000;
        end else if (regRd) begin
            case (regAddr)
                `ACS_OFF_STATUS:  regRdata <= statusWord;
                `ACS_OFF_COMMAND: regRdata <= cmdQ;
                `ACS_OFF_CONTROL: regRdata <= ctlQ;
                default:          regRdata <= 32'h00000000;
            endcase
        end else begin
            regRdata <= 32'h00000000;
        end
    end

    assign portEnable = cmdQ[`ACS_CMD_EN_BIT];
    // Software keeps the rate one-hot; no check here
    assign adRate  = cmdQ[`ACS_CMD_RATE_LSB+2:`ACS_CMD_RATE_LSB];
    assign sbaRate = cmdQ[`ACS_CMD_RATE_LSB+2:`ACS_CMD_RATE_LSB];
    assign pipeAccept = portEnable & pipeReq;
    assign sbaAccept  = portEnable & cmdQ[`ACS_CMD_SBE_BIT] & sbaReq;
    // Already accepted work finishes even after disable
    assign opService = opPending;
endmodule

// ===== verif/acs_regs_chk.sv
`timescale 1ns/100ps
module acs_regs_chk (
    input wire ref_clk, rst, regWr, regRd, pipeReq, sbaReq, opPending,
    input wire [7:0] regAddr,
    input wire [31:0] regWdata, regRdata,
    input wire pipeAccept, sbaAccept, opService, portEnable,
    input wire [2:0] adRate, sbaRate,
    input wire [5:0] queueDepth
);
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
sequence rdStat; $past(regRd) && $past(regAddr) == 8'ha4; endsequence
sequence wrCmd; regWr && regAddr == 8'ha8; endsequence
chk_pipe_gate: assert property (pipeAccept == (portEnable && pipeReq))
    else $error("pipe accept mismatch");
chk_sba_gate: assert property (sbaAccept |-> portEnable && sbaReq)
    else $error("sideband accept while gated");
chk_svc_pass: assert property (opService == opPending)
    else $error("accepted work not serviced");
chk_rate_both: assert property (adRate == sbaRate)
    else $error("bus rates differ");
chk_rd_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside read slot");
chk_stat_fixed: assert property (rdStat |-> regRdata[31:30] == 2'h0
    && regRdata[23:3] == 21'h40) else $error("status fixed bits wrong");
chk_depth_set: assert property (rdStat |-> regRdata[29:24] inside
    {6'h1f, 6'hf, 6'h7, 6'h3, 6'h1, 6'h0}) else $error("bad depth");
chk_en_write: assert property (wrCmd |=> portEnable == $past(regWdata[8]))
    else $error("enable not written");
chk_rate_write: assert property (wrCmd |=> adRate == $past(regWdata[2:0]))
    else $error("rate not written");
cover property (pipeAccept);
cover property (sbaAccept);
cover property (rdStat);
endmodule
bind acs_regs acs_regs_chk i_chk (.*);

// ===== verif/tb.sv
`timescale 1ns/100ps
module tb;
reg ref_clk = 0, rst = 1, regWr = 0, regRd = 0, pipeReq = 0, sbaReq = 0;
reg opPending = 0;
reg [7:0] regAddr = 0;
reg [31:0] regWdata = 0;
wire [31:0] regRdata;
wire pa, sa, os, pe;
wire [2:0] ar, sr;
wire [5:0] qd;
int n_mismatch = 0, n_compared = 0, cyc = 0;
always #25 ref_clk = ~ref_clk;
acs_regs i_dut (.ref_clk, .rst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .pipeReq, .sbaReq, .opPending, .pipeAccept(pa), .sbaAccept(sa),
    .opService(os), .adRate(ar), .sbaRate(sr), .queueDepth(qd), .portEnable(pe));
task summarize;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask
task cmp(string s, logic [31:0] e, logic [31:0] a);
    n_compared++;
    if (a !== e) begin
        n_mismatch++;
        $display("unexpected %s exp %h got %h", s, e, a);
    end
endtask
task wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk); regWr <= 1; regAddr <= a; regWdata <= d;
    @(posedge ref_clk); regWr <= 0; #1;
endtask
task rd(logic [7:0] a, logic [31:0] e);
    @(posedge ref_clk); regRd <= 1; regAddr <= a;
    @(posedge ref_clk); regRd <= 0; #1 cmp("rdata", e, regRdata);
endtask
task t_cmd; // Software keeps one rate bit and fast-write enable low
    wr(8'ha8, 32'hffffffe2); rd(8'ha8, 32'h302);
    cmp("rates", 32'h12, {ar, sr});
    wr(8'ha4, 0); rd(8'ha4, 32'h1f000207);
endtask
task t_gate;
    @(posedge ref_clk);
    pipeReq <= 1; sbaReq <= 1; opPending <= 1; @(posedge ref_clk); #1;
    cmp("acc", 3, {pa, sa});
    wr(8'ha8, 32'h101); cmp("acc", 2, {pa, sa});
    wr(8'ha8, 32'h1); cmp("acc", 0, {pa, sa, pe});
    cmp("svc", 1, os);
endtask
task t_ctl;
    wr(8'hac, 32'h1401); rd(8'ha4, 32'h203);
    cmp("depth", 0, qd);
    wr(8'hac, 32'h1800); rd(8'ha4, 32'h1f000207);
    cmp("depth", 32'h1f, qd);
endtask
always @(posedge ref_clk) if (++cyc > 2000) begin n_mismatch++; summarize; end
initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 0;
    rd(8'ha4, 32'h1f000207);
    rd(8'ha8, 0);
    rd(8'h10, 0);
    t_cmd; t_gate; t_ctl;
    summarize;
end
endmodule
